// *** rtl/fce_regs.svh ***
// Constants for the float compare, estimate and convert slice
//
// Overview of operation
// [RL1] Compare to zero sets zero/negative flags
// [RL2] Compare flags usable by very next instruction
// [RL3] Compare decoded from one word, low source
// [RL4] Negative zero, denormal as zero; NaN as infinity
// [RL5] Reciprocal estimate decoded from two-word opcode
// [RL6] Reciprocal estimate accurate to about eight bits
// [RL7] Reciprocal result never negative zero, denormal, NaN
// [RL8] Reciprocal sets underflow/overflow, other flags untouched
// [RL9] Reciprocal writes destination after one delay slot
// [RL10] Delay slot must not touch pending destination
// [RL11] Inverse root estimate decoded from two words
// [RL12] Inverse root estimate accurate to eight bits
// [RL13] Inverse root result never negative zero, denormal, NaN
// [RL14] Inverse root sets only underflow/overflow latches
// [RL15] Inverse root writes destination after delay slot
// [RL16] Truncating convert decoded, high word zero fields
// [RL17] Convert truncates float toward zero to int16
// [RL18] Convert result sign-extended from bit fifteen
// [RL19] Convert leaves every status flag unchanged
// [RL20] Convert writes destination after one delay slot
// [RL21] Operand fields select one of eight registers
// [RL22] Latched flags stay set until software clears
`ifndef FCE_REGS_SVH
`define FCE_REGS_SVH
`define FCE_OP_CMPZ 13'h1CB4
`define FCE_OP_RCP 16'hE693
`define FCE_OP_RSQ 16'hE692
`define FCE_OP_CVT 16'hE68C
`define FCE_HI_ZERO 10'h000
`define FCE_SRC_MSB 5
`define FCE_SRC_LSB 3
`define FCE_DST_MSB 2
`define FCE_DST_LSB 0
`define FCE_REG_RST 32'h00000000
`define FCE_FLAG_RST 1'b0
`define FCE_EXP_MAX 8'hFF
`define FCE_FLT_BIG 31'h7F7FFFFF
`define FCE_LATENCY 2
`endif

// *** rtl/fce_pkg.sv ***
// Types shared by the float compare, estimate and convert slice
package fce_pkg;
  // One-hot pipeline stage
  typedef enum logic [1:0] {
    FCE_PIPE_IDLE = 2'b01,
    FCE_PIPE_WB = 2'b10
  } fce_pipe_t;
  // Whole state of the top module
  typedef struct packed {
    logic [7:0][31:0] regs;
    logic zf;
    logic nf;
    logic latched_underflow_flag;
    logic latched_overflow_flag;
    fce_pipe_t pipe;
    logic [2:0] pend_dst;
    logic [31:0] pend_data;
    logic pend_cvt;
    logic pend_luf;
    logic pend_lvf;
    logic [31:0] rd_data;
    logic bad_op;
  } fce_state_t;
endpackage

// *** rtl/fce_if.sv ***
// Operand and result bundle between the slice and its arithmetic units
`timescale 1ns/1ps
`default_nettype none
interface fce_if;
  logic [31:0] src;
  logic sqrt_sel;
  logic [31:0] est_res;
  logic est_luf;
  logic est_lvf;
  logic [31:0] cvt_res;
  modport top (output src, output sqrt_sel, input est_res, input est_luf, input est_lvf, input cvt_res);
  modport est (input src, input sqrt_sel, output est_res, output est_luf, output est_lvf);
  modport cvt (input src, output cvt_res);
endinterface
`default_nettype wire

// *** rtl/fce_estimate.sv ***
// Reciprocal and inverse square-root estimate unit
`timescale 1ns/1ps
`default_nettype none
`include "fce_regs.svh"
module fce_estimate (
  fce_if.est bus
);
  import fce_pkg::*;
  // Bitwise integer square root
  function automatic logic [12:0] fce_isqrt(input logic [25:0] v);
    logic [12:0] r;
    logic [12:0] t;
    r = 13'h0000;
    for (int i = 12; i >= 0; i--)
    begin
      t = r | (13'h0001 << i);
      if (({13'h0000, t} * {13'h0000, t}) <= v)
        r = t;
    end
    return r;
  endfunction
  // Range check and packing; never yields NaN, denormal or negative zero
  function automatic logic [33:0] fce_pack(input logic sgn, input logic signed [9:0] ex, input logic [22:0] m);
    if (ex >= 10'sd255)
      return {1'b1, 1'b0, sgn, `FCE_FLT_BIG}; // RL7 RL13
    else if (ex <= 10'sd0)
      return {1'b0, 1'b1, `FCE_REG_RST}; // RL7 RL13
    else
      return {2'b00, sgn, ex[7:0], m};
  endfunction
  logic [7:0] e;
  logic [8:0] m9;
  logic [17:0] q;
  logic signed [9:0] ue;
  logic odd;
  logic signed [9:0] k;
  logic [9:0] v;
  logic [12:0] s;
  logic [24:0] t;
  logic signed [9:0] ex;
  logic [22:0] mt;
  logic [33:0] pk;
  // Eight leading mantissa bits seed both estimates
  always_comb
  begin
    e = bus.src[30:23];
    m9 = {1'b1, bus.src[22:15]};
    q = 18'h20000 / {9'h000, m9};
    ue = $signed({2'b00, e}) - 10'sd127;
    odd = ue[0];
    k = (ue - $signed({9'h000, odd})) >>> 1;
    v = {1'b0, m9} << odd;
    s = fce_isqrt({v, 16'h0000});
    t = 25'h1000000 / {12'h000, s};
    if (bus.sqrt_sel)
    begin
      // Root of magnitude; sign ignored so no NaN arises
      ex = t[12] ? (10'sd127 - k) : (10'sd126 - k); // RL12
      mt = t[12] ? 23'h000000 : {t[10:0], 12'h000}; // RL12
    end
    else
    begin
      ex = q[9] ? (10'sd254 - $signed({2'b00, e})) : (10'sd253 - $signed({2'b00, e})); // RL6
      mt = q[9] ? 23'h000000 : {q[7:0], 15'h0000}; // RL6
    end
    // Zero or denormal input overflows to the largest finite estimate
    if (e == 8'h00)
      ex = 10'sd255; // RL4
    pk = fce_pack(bus.sqrt_sel ? 1'b0 : bus.src[31], ex, mt);
  end
  assign bus.est_res = pk[31:0];
  assign bus.est_lvf = pk[33]; // RL8 RL14
  assign bus.est_luf = pk[32]; // RL8 RL14
endmodule
`default_nettype wire

// *** rtl/fce_convert.sv ***
// Truncating float to signed 16-bit converter
`timescale 1ns/1ps
`default_nettype none
`include "fce_regs.svh"
module fce_convert (
  fce_if.cvt bus
);
  import fce_pkg::*;
  logic [7:0] e;
  logic [7:0] sh;
  logic [23:0] mag;
  logic [15:0] r16;
  // Shift drops fraction bits, which truncates toward zero
  always_comb
  begin
    e = bus.src[30:23];
    sh = e - 8'h7F;
    mag = 24'h000000;
    if (e < 8'h7F)
      r16 = 16'h0000; // RL17
    else if (sh >= 8'h0F)
      // Out of range saturates by sign, NaN included
      r16 = bus.src[31] ? 16'h8000 : 16'h7FFF;
    else
    begin
      mag = {1'b1, bus.src[22:0]} >> (5'd23 - sh[4:0]); // RL17
      r16 = bus.src[31] ? (16'h0000 - mag[15:0]) : mag[15:0]; // RL17
    end
  end
  assign bus.cvt_res = {{16{r16[15]}}, r16}; // RL18
endmodule
`default_nettype wire

// *** rtl/fce_top.sv ***
// Float compare, estimate and convert slice with its register bank
`timescale 1ns/1ps
`default_nettype none
`include "fce_regs.svh"
module fce_top (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_lo_in,
  input wire logic [15:0] instr_hi_in,
  input wire logic reg_wr_en_in,
  input wire logic [2:0] reg_wr_sel_in,
  input wire logic [31:0] reg_wr_data_in,
  input wire logic [2:0] rd_sel_in,
  input wire logic luf_clr_in,
  input wire logic lvf_clr_in,
  output logic [31:0] rd_data_out,
  output logic float_zero_flag_out,
  output logic float_negative_flag_out,
  output logic latched_underflow_flag_out,
  output logic latched_overflow_flag_out,
  output logic wb_busy_out,
  output logic bad_op_out
);
  import fce_pkg::*;

  // One state register holds the bank, the flags and the single result slot.
  // Compare acts at its own issue edge; the estimates and the conversion
  // park their result for one cycle and write it at the end of the slot.
  // No forwarding exists: the issuer keeps the slot free of the pending
  // destination, which is what lets the operand read stay this simple.

  // Reset image of the whole state; constants only, so the
  // asynchronous reset branch never samples live logic
  localparam fce_state_t FCE_ST_RST = '{
    regs: {8{`FCE_REG_RST}},
    zf: `FCE_FLAG_RST,
    nf: `FCE_FLAG_RST,
    latched_underflow_flag: `FCE_FLAG_RST,
    latched_overflow_flag: `FCE_FLAG_RST,
    pipe: FCE_PIPE_IDLE,
    pend_dst: 3'h0,
    pend_data: `FCE_REG_RST,
    pend_cvt: 1'h0,
    pend_luf: 1'h0,
    pend_lvf: 1'h0,
    rd_data: `FCE_REG_RST,
    bad_op: 1'h0
  };

  // Exponent field of zero: true zero, negative zero or denormal
  function automatic logic fce_is_zeroish(input logic [31:0] x);
    return x[30:23] == 8'h00;
  endfunction

  // Source register field of the second opcode word
  function automatic logic [2:0] fce_src_of(input logic [15:0] hi);
    // Three bits reach exactly the eight registers, no range check needed
    return hi[`FCE_SRC_MSB:`FCE_SRC_LSB]; // RL21
  endfunction

  // Destination register field of the second opcode word
  function automatic logic [2:0] fce_dst_of(input logic [15:0] hi);
    return hi[`FCE_DST_MSB:`FCE_DST_LSB]; // RL21
  endfunction

  // Two-word opcode match: exact first word, unused high bits clear
  function automatic logic fce_match2(input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] op);
    // A set top bit marks a rounding variant, which this slice refuses
    return (lo == op) && (hi[15:6] == `FCE_HI_ZERO);
  endfunction

  // Zero and negative flags of a compare against zero, as {zero, negative}
  function automatic logic [1:0] fce_cmp_flags(input logic [31:0] x);
    logic [1:0] f;
    // Zero-like operands all equal zero
    if (fce_is_zeroish(x))
      f = 2'h2; // RL1 RL4
    // Any other pattern, NaN included, orders by its sign alone
    else
      f = {1'h0, x[31]}; // RL1 RL4
    return f;
  endfunction

  // Registered state and its next value
  fce_state_t st_r;
  fce_state_t st_nxt;
  // Decoded opcode kinds of the word on the issue port
  logic op_cmp;
  logic op_rcp;
  logic op_rsq;
  logic op_cvt;
  // Any two-cycle operation
  logic op_two;
  // Any opcode this slice knows
  logic op_known;
  // Selected source register number
  logic [2:0] src_sel;
  // Selected source register contents
  logic [31:0] src_val;
  // Bundle to the two arithmetic units
  fce_if u_bus ();

  // Compare against zero: thirteen fixed bits, register in the low three
  assign op_cmp = (instr_lo_in[15:3] == `FCE_OP_CMPZ); // RL3
  // Reciprocal estimate
  assign op_rcp = fce_match2(instr_lo_in, instr_hi_in, `FCE_OP_RCP); // RL5
  // Inverse square-root estimate
  assign op_rsq = fce_match2(instr_lo_in, instr_hi_in, `FCE_OP_RSQ); // RL11
  // Truncating conversion; the rounding variant falls out as unknown
  assign op_cvt = fce_match2(instr_lo_in, instr_hi_in, `FCE_OP_CVT); // RL16
  // Group of two-cycle operations
  assign op_two = op_rcp | op_rsq | op_cvt;
  // Anything else raises the bad opcode output
  assign op_known = op_cmp | op_two;
  // Compare carries its register in the first word, the others in the second
  assign src_sel = op_cmp ? instr_lo_in[2:0] : fce_src_of(instr_hi_in); // RL3 RL21
  // Plain bank read; a pending result is not forwarded
  assign src_val = st_r.regs[src_sel];
  // Operand to both units
  assign u_bus.src = src_val;
  // Unit picks the inverse root only for that opcode
  assign u_bus.sqrt_sel = op_rsq;

  // Reciprocal and inverse root estimates, purely combinational
  fce_estimate u_est (
    .bus(u_bus)
  );

  // Truncating conversion, purely combinational
  fce_convert u_cvt (
    .bus(u_bus)
  );

  // Next state: read port, clears, software load, writeback, then issue.
  // The order matters: clears before writeback so a raised latch wins,
  // software load before writeback so a finishing result wins.
  always_comb
  begin
    // Hold everything by default
    st_nxt = st_r;
    // Read port is registered, so its data stands a cycle after the select
    st_nxt.rd_data = st_r.regs[rd_sel_in];
    // Software clears of the latches
    if (luf_clr_in)
      st_nxt.latched_underflow_flag = 1'h0; // RL22
    if (lvf_clr_in)
      st_nxt.latched_overflow_flag = 1'h0; // RL22
    // Direct software load of one register
    if (reg_wr_en_in)
      st_nxt.regs[reg_wr_sel_in] = reg_wr_data_in;
    // Writeback stage
    case (st_r.pipe)
      FCE_PIPE_IDLE:
        st_nxt.pipe = FCE_PIPE_IDLE;
      FCE_PIPE_WB:
      begin
        // Result of the operation issued one cycle ago
        st_nxt.regs[st_r.pend_dst] = st_r.pend_data; // RL9 RL15 RL20
        // Conversion touches no flag at all
        if (!st_r.pend_cvt)
        begin
          // Latches only ever set here; only software lowers them
          st_nxt.latched_underflow_flag = st_nxt.latched_underflow_flag | st_r.pend_luf; // RL8 RL14 RL22
          st_nxt.latched_overflow_flag = st_nxt.latched_overflow_flag | st_r.pend_lvf; // RL8 RL14 RL22
        end
        // Back to idle unless a new issue below refills the slot
        st_nxt.pipe = FCE_PIPE_IDLE;
      end
      // Illegal code: drop it and recover to idle
      default:
        st_nxt.pipe = FCE_PIPE_IDLE;
    endcase
    // Issue stage
    if (instr_valid_in)
    begin
      // Unknown words are flagged and otherwise ignored
      st_nxt.bad_op = !op_known; // RL16
      // Compare finishes in this cycle; flags usable by the next instruction
      if (op_cmp)
        {st_nxt.zf, st_nxt.nf} = fce_cmp_flags(src_val); // RL1 RL2
      // Two-cycle operations park their result for one cycle
      if (op_two)
      begin
        st_nxt.pend_dst = fce_dst_of(instr_hi_in); // RL21
        st_nxt.pend_data = op_cvt ? u_bus.cvt_res : u_bus.est_res; // RL6 RL12 RL17
        st_nxt.pend_cvt = op_cvt; // RL19
        // Estimates raise only the two latches; zero and negative stay
        st_nxt.pend_luf = op_cvt ? 1'h0 : u_bus.est_luf; // RL8 RL14
        st_nxt.pend_lvf = op_cvt ? 1'h0 : u_bus.est_lvf; // RL8 RL14
        // Stage entered for the delay slot
        st_nxt.pipe = FCE_PIPE_WB; // RL9 RL15 RL20
      end
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      st_r <= FCE_ST_RST;
    else
      st_r <= st_nxt;
  end

  // Every output is a bit of the state register
  assign rd_data_out = st_r.rd_data;
  assign float_zero_flag_out = st_r.zf;
  assign float_negative_flag_out = st_r.nf;
  assign latched_underflow_flag_out = st_r.latched_underflow_flag;
  assign latched_overflow_flag_out = st_r.latched_overflow_flag;
  // One-hot code: the upper bit is the writeback state itself
  assign wb_busy_out = st_r.pipe[1];
  assign bad_op_out = st_r.bad_op;

  // Checks run on the core clock and rest while reset is low
  default clocking fce_cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Issue of a two-cycle operation
  sequence fce_issue_two_s;
    instr_valid_in && op_two;
  endsequence

  // Delay-slot cycle with a result waiting
  sequence fce_slot_s;
    wb_busy_out;
  endsequence

  // Delay-slot cycle of a conversion
  sequence fce_cvt_slot_s;
    wb_busy_out && st_r.pend_cvt;
  endsequence

  // Compare of a zero-like operand
  sequence fce_cmp_zero_s;
    instr_valid_in && op_cmp && fce_is_zeroish(src_val);
  endsequence

  // Compare of any other operand
  sequence fce_cmp_other_s;
    instr_valid_in && op_cmp && !fce_is_zeroish(src_val);
  endsequence

  // Zero-like operand leaves zero set and negative clear
  property fce_cmp_zero_p;
    fce_cmp_zero_s |=> float_zero_flag_out && !float_negative_flag_out;
  endproperty
  cmp_zero_flags_a: assert property (fce_cmp_zero_p) // RL1 RL4
    else $error("compare of a zero-like operand gave wrong flags");

  // Other operands order by sign, so NaN counts as an infinity
  property fce_cmp_sign_p;
    fce_cmp_other_s |=> !float_zero_flag_out
      && (float_negative_flag_out == $past(src_val[31]));
  endproperty
  cmp_sign_flags_a: assert property (fce_cmp_sign_p) // RL1 RL2
    else $error("compare of a nonzero operand gave wrong flags");

  // Two-cycle operation occupies the very next cycle's slot
  property fce_latency_p;
    fce_issue_two_s |=> fce_slot_s;
  endproperty
  pipe_latency_a: assert property (fce_latency_p) // RL9 RL15 RL20
    else $error("two-cycle operation did not enter its slot");

  // Result lands in its destination at the end of the slot
  property fce_writeback_p;
    fce_slot_s |=> (st_r.regs[$past(st_r.pend_dst)] == $past(st_r.pend_data));
  endproperty
  slot_writeback_a: assert property (fce_writeback_p) // RL9 RL15 RL20
    else $error("pending result was not written back");

  // Conversion result is sign-extended from bit fifteen
  property fce_sign_ext_p;
    fce_cvt_slot_s |-> (st_r.pend_data[31:16] == {16{st_r.pend_data[15]}});
  endproperty
  cvt_sign_ext_a: assert property (fce_sign_ext_p) // RL18
    else $error("conversion result upper half is not a sign copy");

  // Conversion leaves both latches as they were
  property fce_cvt_flags_p;
    fce_cvt_slot_s ##0 (!luf_clr_in && !lvf_clr_in) |=> $stable(latched_underflow_flag_out)
      && $stable(latched_overflow_flag_out);
  endproperty
  cvt_flags_kept_a: assert property (fce_cvt_flags_p) // RL19
    else $error("conversion changed a latched flag");

  // Writeback of any two-cycle result leaves zero and negative alone
  property fce_slot_cmp_flags_p;
    fce_slot_s ##0 !(instr_valid_in && op_cmp) |=> $stable(float_zero_flag_out)
      && $stable(float_negative_flag_out);
  endproperty
  slot_keeps_flags_a: assert property (fce_slot_cmp_flags_p) // RL8 RL14 RL19
    else $error("two-cycle writeback changed zero or negative");

  // Estimate result never NaN, infinity, negative zero or denormal
  property fce_est_legal_p;
    fce_issue_two_s ##0 !op_cvt |=> (st_r.pend_data[30:23] != `FCE_EXP_MAX)
      && (st_r.pend_data != 32'h80000000)
      && (!fce_is_zeroish(st_r.pend_data) || (st_r.pend_data[22:0] == 23'h000000));
  endproperty
  est_result_legal_a: assert property (fce_est_legal_p) // RL7 RL13
    else $error("estimate produced an illegal value");

  // Underflow latch holds until software clears it
  property fce_luf_sticky_p;
    latched_underflow_flag_out && !luf_clr_in |=> latched_underflow_flag_out;
  endproperty
  luf_sticky_a: assert property (fce_luf_sticky_p) // RL22
    else $error("underflow latch dropped without a clear");

  // Overflow latch holds until software clears it
  property fce_lvf_sticky_p;
    latched_overflow_flag_out && !lvf_clr_in |=> latched_overflow_flag_out;
  endproperty
  lvf_sticky_a: assert property (fce_lvf_sticky_p) // RL22
    else $error("overflow latch dropped without a clear");

  // Unknown or rounding opcodes are flagged, never executed
  property fce_bad_op_p;
    instr_valid_in && !op_known |=> bad_op_out;
  endproperty
  bad_opcode_a: assert property (fce_bad_op_p) // RL16
    else $error("unknown opcode was not flagged");
endmodule
`default_nettype wire

// *** sim/fce_core_model.sv ***
// Instruction issuer standing in for the core pipeline
`timescale 1ns/1ps
`default_nettype none
module fce_core_model (
  input wire logic clk_in,
  output logic valid_out,
  output logic [15:0] lo_out,
  output logic [15:0] hi_out
);
  initial {valid_out, lo_out, hi_out} = 33'h0;
  // One instruction, then a bubble so the slot never touches the pending destination
  task issue(input logic [15:0] lo, input logic [15:0] hi);
    @(negedge clk_in);
    {valid_out, lo_out, hi_out} = {1'b1, lo, hi};
    @(negedge clk_in);
    valid_out = 1'b0;
    {lo_out, hi_out} = ~{lo, hi}; // Stale words inverted, never left looking valid
    @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// *** sim/float_compare_estimate_convert_test.sv ***
// Self-checking bench for the compare, estimate and convert slice
`timescale 1ns/1ps
`default_nettype none
`include "fce_regs.svh"
module float_compare_estimate_convert_test;
  logic clk_in = 0, reset_n_in = 0, we = 0, luc = 0, lvc = 0;
  logic [2:0] ws = 0, rs = 0;
  logic [31:0] wd = 0, v;
  wire logic iv, zf, nf, latched_underflow_flag, latched_overflow_flag, bz, bo;
  wire logic [15:0] il, ih;
  wire logic [31:0] rd;
  int err_total = 0, n_compared = 0;
  fce_core_model core (.clk_in(clk_in), .valid_out(iv), .lo_out(il), .hi_out(ih));
  fce_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .instr_valid_in(iv), .instr_lo_in(il),
    .instr_hi_in(ih), .reg_wr_en_in(we), .reg_wr_sel_in(ws), .reg_wr_data_in(wd), .rd_sel_in(rs),
    .luf_clr_in(luc), .lvf_clr_in(lvc), .rd_data_out(rd), .float_zero_flag_out(zf),
    .float_negative_flag_out(nf), .latched_underflow_flag_out(latched_underflow_flag), .latched_overflow_flag_out(latched_overflow_flag),
    .wb_busy_out(bz), .bad_op_out(bo));
  // Free-running core clock
  initial forever #12.5 clk_in = ~clk_in;
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [2:0] s, input logic [31:0] d);
    @(negedge clk_in);
    {we, ws, wd} = {1'b1, s, d};
    @(negedge clk_in);
    we = 1'b0;
  endtask
  // Read back through the registered port
  task rdv(input logic [2:0] s);
    @(negedge clk_in);
    rs = s;
    repeat (2) @(negedge clk_in);
    v = rd;
  endtask
  // Two-word op: source then destination field
  task op2(input logic [15:0] lo, input logic [2:0] s, input logic [2:0] d);
    core.issue(lo, {10'h000, s, d});
  endtask
  task automatic t_cmp;
    logic [31:0] x [6] = '{32'h40A00000, 32'hC0000000, 0, 32'h80000000, 32'h00000001, 32'h7FC00000};
    logic [1:0] f [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h0};
    for (int i = 0; i < 6; i++)
    begin
      wr(3'(i), x[i]);
      core.issue({`FCE_OP_CMPZ, 3'(i)}, 16'h0000);
      chk("cmp flags", {30'h0, f[i]}, {30'h0, zf, nf});
    end
    $display("compare done");
  endtask
  task automatic t_cvt;
    logic [31:0] x [3] = '{32'h40A00000, 32'hC0B00000, 32'h46FFFF00};
    logic [31:0] e [3] = '{32'h00000005, 32'hFFFFFFFB, 32'h00007FFF};
    for (int i = 0; i < 3; i++)
    begin
      wr(3'd1, x[i]);
      core.issue({`FCE_OP_CMPZ, 3'd1}, 16'h0000);
      op2(`FCE_OP_CVT, 3'd1, 3'd2);
      rdv(3'd2);
      chk("cvt", e[i], v);
      chk("cvt flags", {28'h0, 1'b0, x[i][31], 2'b00}, {28'h0, zf, nf, latched_underflow_flag, latched_overflow_flag});
    end
    $display("convert done");
  endtask
  task t_est;
    wr(3'd3, 32'h40000000);
    op2(`FCE_OP_RCP, 3'd3, 3'd4);
    rdv(3'd4);
    chk("rcp near", 1, 32'((v - 32'h3F000000 + 32'h8000) < 32'h10000));
    wr(3'd5, 32'h40800000);
    op2(`FCE_OP_RSQ, 3'd5, 3'd6);
    rdv(3'd6);
    chk("rsq near", 1, 32'((v - 32'h3F000000 + 32'h8000) < 32'h10000));
    chk("est flags", 0, {28'h0, zf, nf, latched_underflow_flag, latched_overflow_flag});
    $display("estimate done");
  endtask
  task t_latch;
    wr(3'd0, 0);
    op2(`FCE_OP_RCP, 3'd0, 3'd7);
    rdv(3'd7);
    chk("rcp ovf", 2'h1, {30'h0, latched_underflow_flag, latched_overflow_flag});
    chk("rcp not nan", 1, 32'(v[30:23] != 8'hFF));
    wr(3'd0, 32'h7F7FFFFF);
    op2(`FCE_OP_RSQ, 3'd0, 3'd7);
    op2(`FCE_OP_RCP, 3'd0, 3'd7);
    rdv(3'd7);
    chk("rcp unf", 2'h3, {30'h0, latched_underflow_flag, latched_overflow_flag});
    chk("rcp not denorm", 1, 32'((v[30:23] != 0 || v[22:0] == 0) && v != 32'h80000000));
    {luc, lvc} = 2'b10;
    @(negedge clk_in);
    {luc, lvc} = 2'b01;
    @(negedge clk_in);
    lvc = 1'b0;
    chk("cleared", 0, {30'h0, latched_underflow_flag, latched_overflow_flag});
    $display("latch done");
  endtask
  // Slot busy output and refusal of the rounding variant
  task t_misc;
    wr(3'd2, 32'h40A00000);
    fork
      op2(`FCE_OP_CVT, 3'd2, 3'd3);
      begin
        repeat (2) @(negedge clk_in);
        chk("slot busy", 1, {31'h0, bz});
      end
    join
    chk("slot idle", 0, {31'h0, bz});
    core.issue(`FCE_OP_CVT, 16'h8015);
    chk("round refused", 1, {31'h0, bo});
    rdv(3'd5);
    chk("round no write", 32'h40800000, v);
    core.issue({`FCE_OP_CMPZ, 3'd2}, 16'h0000);
    chk("known op", 0, {31'h0, bo});
    $display("misc done");
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge clk_in);
    reset_n_in = 1'b1;
    t_cmp();
    t_cvt();
    t_est();
    t_latch();
    t_misc();
    tally_and_finish();
  end
  // Whole run is about a hundred and thirty cycles
  initial
  begin
    #50000;
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
